//--- bpio_params.svh
// What this block does
// - Eight pins per port, each configured alone
// - Register bit x steers pin x
// - Reset clears registers: pull-up inputs, no interrupts
// - Input pins: data read returns pin level
// - Input, option 0: data selects pull-up or none
// - Input, option 1, data 0: pull-up with interrupt
// - Input, option 1, data 1: analog input, except port 0 pins 0-3
// - Output pins: latch drives pin, read returns latch
// - Output, option 0: open-drain, low or floating
// - Output, option 1: push-pull from data bit
// - Interrupt only if configured and globally enabled
// - Falling, rising, low-level triggers per port group
// - Sleep keeps ports; enabled pin interrupt wakes
// - Global enable low: NMI cannot wake
// - No sleep entry while enabled request pending
// - Data registers at consecutive addresses, read/write
// - First vector: falling edge or low level
// - Shared vector: falling or rising edge
`ifndef BPIO_PARAMS_SVH
`define BPIO_PARAMS_SVH

`define BPIO_NPORTS 3
`define BPIO_WIDTH 8
`define BPIO_ADDR_DATA 8'hC0
`define BPIO_ADDR_DIR 8'hC4
`define BPIO_ADDR_IRQ_OPT 8'hC8
`define BPIO_ADDR_OPT 8'hCC
`define BPIO_IRQ_LEVEL_BIT 6
`define BPIO_IRQ_POL_BIT 5
`define BPIO_IRQ_ENABLE_BIT 4
`define BPIO_RESET_BYTE 8'h00
`define BPIO_ANALOG_MASK 24'hFFFFF0

`endif

//--- bpio_pkg.sv
package bpio_pkg;

	typedef enum logic [2:0] {
		BPIO_RUN = 3'h1,
		BPIO_WAIT = 3'h2,
		BPIO_STOP = 3'h4
	} bpio_pwr_type;

endpackage : bpio_pkg

//--- bpio_sync.sv
`timescale 1ns/1ps
`include "bpio_params.svh"

module bpio_sync #(
	parameter int WIDTH = `BPIO_WIDTH
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Raw pins and clean levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] level
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	// Idle pins sit pulled up, so reset to ones
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			stage1 <= '1;
			stage2 <= '1;
			stage3 <= '1;
		end else begin
			stage1 <= async_in;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// A level is taken only once two stages agree
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			level <= '1;
		end else begin
			level <= (~(stage2 ^ stage3) & stage3) | ((stage2 ^ stage3) & level);
		end
	end

endmodule : bpio_sync

//--- bpio_port.sv
`timescale 1ns/1ps
`include "bpio_params.svh"

module bpio_port #(
	parameter int WIDTH = `BPIO_WIDTH,
	parameter logic [`BPIO_NPORTS*`BPIO_WIDTH-1:0] ANALOG_MASK = `BPIO_ANALOG_MASK
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Pins, port 0 in the low byte
	input wire logic [`BPIO_NPORTS*`BPIO_WIDTH-1:0] pin_in,
	output logic [`BPIO_NPORTS*`BPIO_WIDTH-1:0] pin_out,
	output logic [`BPIO_NPORTS*`BPIO_WIDTH-1:0] pin_oe,
	output logic [`BPIO_NPORTS*`BPIO_WIDTH-1:0] pin_pullup_en,
	output logic [`BPIO_NPORTS*`BPIO_WIDTH-1:0] pin_analog_en,
	// Interrupt requests to the core
	input wire logic irq_ack1,
	input wire logic irq_ack2,
	input wire logic nmi_req,
	output logic irq_vec1,
	output logic irq_vec2,
	// Power modes
	input wire logic wait_req,
	input wire logic stop_req,
	output logic wait_active,
	output logic stop_active,
	output logic wake_pulse,
	output logic sleep_refused
);

	localparam int NP = `BPIO_NPORTS;
	localparam int PW = NP * WIDTH;

	////////////////////////////////////////////////////////////////////////////////
	// Registers

	logic [PW-1:0] pin_data_latch;
	logic [PW-1:0] pin_direction;
	logic [PW-1:0] port_option;
	logic vector1_level_edge_select;
	logic vector2_edge_polarity;
	logic global_irq_enable;

	logic [PW-1:0] pin_level;
	logic [PW-1:0] pin_level_d;
	logic pend1;
	logic pend2;
	bpio_pkg::bpio_pwr_type pwr_state;
	bpio_pkg::bpio_pwr_type next_pwr_state;

	logic [7:0] next_rdata;
	logic [PW-1:0] data_view;
	logic [PW-1:0] eligible;
	logic [PW-1:0] fall;
	logic [PW-1:0] rise;
	logic [PW-1:0] sel_edge;
	logic ev1;
	logic ev2;
	logic low1;
	logic req1;
	logic req2;
	logic irq_pending;
	logic wake_cond;
	logic refuse;

	// Per-port data, direction and option bytes
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pin_data_latch <= '0;
			pin_direction <= '0;
			port_option <= '0;
		end else begin
			for (int p = 0; p < NP; p++) begin
				if (reg_wr && reg_addr == `BPIO_ADDR_DATA + 8'(p)) begin
					pin_data_latch[p*WIDTH +: WIDTH] <= reg_wdata[WIDTH-1:0];
				end
				if (reg_wr && reg_addr == `BPIO_ADDR_DIR + 8'(p)) begin
					pin_direction[p*WIDTH +: WIDTH] <= reg_wdata[WIDTH-1:0];
				end
				if (reg_wr && reg_addr == `BPIO_ADDR_OPT + 8'(p)) begin
					port_option[p*WIDTH +: WIDTH] <= reg_wdata[WIDTH-1:0];
				end
			end
		end
	end

	// Interrupt option register, write only
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			vector1_level_edge_select <= 1'b0;
			vector2_edge_polarity <= 1'b0;
			global_irq_enable <= 1'b0;
		end else if (reg_wr && reg_addr == `BPIO_ADDR_IRQ_OPT) begin
			vector1_level_edge_select <= reg_wdata[`BPIO_IRQ_LEVEL_BIT];
			vector2_edge_polarity <= reg_wdata[`BPIO_IRQ_POL_BIT];
			global_irq_enable <= reg_wdata[`BPIO_IRQ_ENABLE_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read path

	// Input bits show the pin, output bits show the latch
	assign data_view = (pin_direction & pin_data_latch) | (~pin_direction & pin_level);

	always_comb begin
		next_rdata = `BPIO_RESET_BYTE;
		if (reg_rd) begin
			for (int p = 0; p < NP; p++) begin
				if (reg_addr == `BPIO_ADDR_DATA + 8'(p)) begin
					next_rdata = data_view[p*WIDTH +: WIDTH];
				end
				if (reg_addr == `BPIO_ADDR_DIR + 8'(p)) begin
					next_rdata = pin_direction[p*WIDTH +: WIDTH];
				end
				if (reg_addr == `BPIO_ADDR_OPT + 8'(p)) begin
					next_rdata = port_option[p*WIDTH +: WIDTH];
				end
			end
		end
	end

	// Data stand only in the cycle after the strobe
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			reg_rdata <= `BPIO_RESET_BYTE;
		end else begin
			reg_rdata <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and pad controls

	genvar gp;
	generate
		for (gp = 0; gp < NP; gp++) begin : g_port
			bpio_sync #(
				.WIDTH(WIDTH)
			) u_sync (
				.ref_clk(ref_clk),
				.srst(srst),
				.async_in(pin_in[gp*WIDTH +: WIDTH]),
				.level(pin_level[gp*WIDTH +: WIDTH])
			);
		end
	endgenerate

	// Every pin decodes its own three bits, no cross-pin terms
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pin_oe <= '0;
			pin_out <= '0;
			pin_pullup_en <= '1;
			pin_analog_en <= '0;
		end else begin
			pin_oe <= pin_direction & (port_option | ~pin_data_latch);
			pin_out <= pin_direction & port_option & pin_data_latch;
			pin_pullup_en <= ~pin_direction & ~pin_data_latch;
			pin_analog_en <= ~pin_direction & port_option & pin_data_latch & ANALOG_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// External interrupts

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pin_level_d <= '1;
		end else begin
			pin_level_d <= pin_level;
		end
	end

	assign eligible = ~pin_direction & port_option & ~pin_data_latch;
	assign fall = pin_level_d & ~pin_level;
	assign rise = ~pin_level_d & pin_level;
	assign sel_edge = vector2_edge_polarity ? rise : fall;
	assign ev1 = global_irq_enable && |(fall[WIDTH-1:0] & eligible[WIDTH-1:0]);
	assign ev2 = global_irq_enable && |(sel_edge[PW-1:WIDTH] & eligible[PW-1:WIDTH]);
	assign low1 = |(~pin_level[WIDTH-1:0] & eligible[WIDTH-1:0]);

	// A new edge in the ack cycle keeps the latch set
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pend1 <= 1'b0;
		end else if (ev1) begin
			pend1 <= 1'b1;
		end else if (irq_ack1 || !global_irq_enable) begin
			pend1 <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pend2 <= 1'b0;
		end else if (ev2) begin
			pend2 <= 1'b1;
		end else if (irq_ack2 || !global_irq_enable) begin
			pend2 <= 1'b0;
		end
	end

	// Low level mode is not latched: it follows the pins
	assign req1 = global_irq_enable && (vector1_level_edge_select ? low1 : pend1);
	assign req2 = global_irq_enable && pend2;
	assign irq_pending = req1 || req2;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			irq_vec1 <= 1'b0;
			irq_vec2 <= 1'b0;
		end else begin
			irq_vec1 <= req1;
			irq_vec2 <= req2;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Power modes; they never touch the port registers

	// Clock keeps running in stop here; the real clock gating sits outside
	assign wake_cond = irq_pending || (nmi_req && global_irq_enable);
	assign refuse = (wait_req || stop_req) && irq_pending;

	always_comb begin
		next_pwr_state = pwr_state;
		unique case (pwr_state)
			bpio_pkg::BPIO_RUN: begin
				if (!refuse && stop_req) begin
					next_pwr_state = bpio_pkg::BPIO_STOP;
				end else if (!refuse && wait_req) begin
					next_pwr_state = bpio_pkg::BPIO_WAIT;
				end
			end
			bpio_pkg::BPIO_WAIT, bpio_pkg::BPIO_STOP: begin
				if (wake_cond) begin
					next_pwr_state = bpio_pkg::BPIO_RUN;
				end
			end
			default: begin
				next_pwr_state = bpio_pkg::BPIO_RUN;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pwr_state <= bpio_pkg::BPIO_RUN;
			wait_active <= 1'b0;
			stop_active <= 1'b0;
			wake_pulse <= 1'b0;
			sleep_refused <= 1'b0;
		end else begin
			pwr_state <= next_pwr_state;
			wait_active <= next_pwr_state == bpio_pkg::BPIO_WAIT;
			stop_active <= next_pwr_state == bpio_pkg::BPIO_STOP;
			wake_pulse <= pwr_state != bpio_pkg::BPIO_RUN && next_pwr_state == bpio_pkg::BPIO_RUN;
			sleep_refused <= pwr_state == bpio_pkg::BPIO_RUN && refuse;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (srst);

	property p_reset_state;
		@(posedge ref_clk) disable iff (1'b0)
		srst |=> pin_oe == '0 && pin_pullup_en == '1 && !irq_vec1 && !irq_vec2;
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

	property p_drive;
		##1 pin_oe == ($past(pin_direction) & ($past(port_option) | ~$past(pin_data_latch)))
			&& pin_out == ($past(pin_direction) & $past(port_option) & $past(pin_data_latch));
	endproperty
	a_drive: assert property (p_drive) else $error("pin drive mismatch");

	property p_pullup;
		##1 pin_pullup_en == (~$past(pin_direction) & ~$past(pin_data_latch));
	endproperty
	a_pullup: assert property (p_pullup) else $error("pull-up mismatch");

	property p_analog;
		##1 pin_analog_en == (~$past(pin_direction) & $past(port_option)
			& $past(pin_data_latch) & ANALOG_MASK);
	endproperty
	a_analog: assert property (p_analog) else $error("analog select mismatch");

	property p_data_read;
		reg_rd && reg_addr == `BPIO_ADDR_DATA |=> reg_rdata == $past(data_view[WIDTH-1:0]);
	endproperty
	a_data_read: assert property (p_data_read) else $error("data read wrong");

	property p_gen_gate;
		!global_irq_enable |=> !irq_vec1 && !irq_vec2;
	endproperty
	a_gen_gate: assert property (p_gen_gate) else $error("irq without enable");

	sequence s_sleep_blocked;
		pwr_state == bpio_pkg::BPIO_RUN && (wait_req || stop_req) && irq_pending;
	endsequence
	property p_no_sleep;
		s_sleep_blocked |=> pwr_state == bpio_pkg::BPIO_RUN && sleep_refused;
	endproperty
	a_no_sleep: assert property (p_no_sleep) else $error("slept with pending irq");

	sequence s_asleep_irq;
		pwr_state != bpio_pkg::BPIO_RUN && irq_pending;
	endsequence
	property p_wake;
		s_asleep_irq |=> pwr_state == bpio_pkg::BPIO_RUN && wake_pulse;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake on irq");

	property p_nmi_no_wake;
		pwr_state == bpio_pkg::BPIO_STOP && nmi_req && !global_irq_enable && !irq_pending
			|=> pwr_state == bpio_pkg::BPIO_STOP;
	endproperty
	a_nmi_no_wake: assert property (p_nmi_no_wake) else $error("nmi woke with gen low");

	property p_level_mode;
		global_irq_enable && vector1_level_edge_select && low1 |=> irq_vec1;
	endproperty
	a_level_mode: assert property (p_level_mode) else $error("low level missed");

	// Enable must survive the latch cycle, a write may drop it there
	sequence s_vec2_event;
		ev2 ##1 global_irq_enable;
	endsequence
	property p_vec2_edge;
		s_vec2_event |=> irq_vec2;
	endproperty
	a_vec2_edge: assert property (p_vec2_edge) else $error("vec2 edge missed");

	property p_wait_entry;
		pwr_state == bpio_pkg::BPIO_RUN && wait_req && !stop_req && !irq_pending
			|=> wait_active;
	endproperty
	a_wait_entry: assert property (p_wait_entry) else $error("wait not entered");

endmodule : bpio_port

//--- bpio_pin_model.sv
`timescale 1ns/1ps
module bpio_pin_model (
	// Clock for the floating pattern
	input wire logic ref_clk,
	// Pad controls from the port
	input wire logic [23:0] pin_out,
	input wire logic [23:0] pin_oe,
	input wire logic [23:0] pin_pullup_en,
	// Outside drivers set by the bench
	input wire logic [23:0] ext_en,
	input wire logic [23:0] ext_val,
	// Resolved pad level
	output logic [23:0] pin_level
);
	logic [23:0] float_pat = 24'h5A5A5A;
	////////////////////////////////////////
	// A floating pad has no fixed level, so it toggles rather than hold a stale value
	always @(posedge ref_clk) begin
		float_pat <= ~float_pat;
	end
	always_comb begin
		for (int i = 0; i < 24; i++) begin
			if (pin_oe[i]) begin
				pin_level[i] = pin_out[i];
			end else if (ext_en[i]) begin
				pin_level[i] = ext_val[i];
			end else if (pin_pullup_en[i]) begin
				pin_level[i] = 1'b1;
			end else begin
				pin_level[i] = float_pat[i];
			end
		end
	end
endmodule : bpio_pin_model

//--- bidir_port_with_pin_interrupts_tb_top.sv
`timescale 1ns/1ps
module bidir_port_with_pin_interrupts_tb_top;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic [23:0] pin_in, pin_out, pin_oe, pin_pullup_en, pin_analog_en;
	logic irq_ack1 = 1'b0, irq_ack2 = 1'b0, nmi_req = 1'b0, wait_req = 1'b0, stop_req = 1'b0;
	logic irq_vec1, irq_vec2, wait_active, stop_active, wake_pulse, sleep_refused;
	logic [23:0] ext_en = 24'h000000;
	logic [23:0] ext_val = 24'h000000;
	logic [31:0] seed = 32'h00004700;
	logic [7:0] r;
	logic rd_q = 1'b0;
	logic [7:0] exp_q[$];
	int err_count = 0;
	int tests_run = 0;

	bpio_port uut (.ref_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.pin_in, .pin_out, .pin_oe, .pin_pullup_en, .pin_analog_en, .irq_ack1, .irq_ack2,
		.nmi_req, .irq_vec1, .irq_vec2, .wait_req, .stop_req, .wait_active, .stop_active,
		.wake_pulse, .sleep_refused);
	bpio_pin_model pads (.ref_clk, .pin_out, .pin_oe, .pin_pullup_en, .ext_en, .ext_val,
		.pin_level(pin_in));

	initial begin
		forever #2.5 ref_clk = ~ref_clk;
	end
	////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// Strobes drop at the next wait, so each stays exactly one cycle
	task automatic tick;
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		@(posedge ref_clk);
	endtask : tick
	task automatic settle(input int n);
		repeat (n) tick();
		#1;
	endtask : settle
	task automatic bus(input logic w, input logic rd, input logic [7:0] a, input logic [7:0] d);
		reg_wr <= w;
		reg_rd <= rd;
		reg_addr <= a;
		reg_wdata <= d;
		if (rd) exp_q.push_back(d);
		@(posedge ref_clk);
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, 1'b0, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, 1'b1, a, e);
	endtask : rd
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_bit(input logic got, input logic exp);
		chk({23'h000000, got}, {23'h000000, exp});
	endtask : chk_bit
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		chk({16'h0000, got}, {16'h0000, exp});
	endtask : chk_byte
	task automatic wait_sig(input int which);
		for (int i = 0; i < 20; i++) begin
			if ((which == 1 ? irq_vec1 : which == 2 ? irq_vec2 : wake_pulse) === 1'b1) break;
			settle(1);
		end
	endtask : wait_sig
	task automatic stop_test;
		if (err_count == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : stop_test
	////////////////////////////////////////
	// Read data stands only in the cycle after the strobe
	always @(posedge ref_clk) begin
		if (rd_q) chk({16'h0000, reg_rdata}, {16'h0000, exp_q.pop_front()});
		rd_q <= reg_rd;
	end
	initial begin
		repeat (3000) @(posedge ref_clk);
		err_count++;
		stop_test();
	end
	initial begin
		repeat (4) tick();
		srst <= 1'b0;
		settle(1);
		chk(pin_pullup_en, 24'hFFFFFF);
		chk(pin_oe | pin_analog_en, 24'h000000);
		for (int a = 0; a < 3; a++) begin
			rd(8'(8'hC0 + a), 8'hFF);
			rd(8'(8'hC4 + a), 8'h00);
			rd(8'(8'hCC + a), 8'h00);
		end
		rd(8'hC8, 8'h00);
		rd(8'hD0, 8'h00);
		seed = lfsr(seed);
		r = seed[15:8];
		ext_en <= 24'hFF0000;
		ext_val <= {r, 16'h0000};
		settle(6);
		rd(8'hC2, r);
		// Whole-byte writes only, never read-modify-write on inputs
		wr(8'hCC, 8'h10);
		bus(1'b0, 1'b0, 8'h00, 8'h00);
		ext_en <= 24'h000010;
		ext_val <= 24'h000000;
		settle(10);
		chk_bit(irq_vec1, 1'b0);
		wr(8'hC8, 8'h10);
		ext_val <= 24'h000010;
		settle(6);
		ext_val <= 24'h000000;
		wait_sig(1);
		chk_bit(irq_vec1, 1'b1);
		wait_req <= 1'b1;
		tick();
		wait_req <= 1'b0;
		settle(0);
		chk_bit(sleep_refused, 1'b1);
		chk_bit(wait_active, 1'b0);
		irq_ack1 <= 1'b1;
		tick();
		irq_ack1 <= 1'b0;
		wr(8'hC8, 8'h00);
		stop_req <= 1'b1;
		tick();
		stop_req <= 1'b0;
		nmi_req <= 1'b1;
		settle(10);
		chk_bit(stop_active, 1'b1);
		chk_bit(irq_vec1, 1'b0);
		nmi_req <= 1'b0;
		wr(8'hC8, 8'h10);
		ext_val <= 24'h000010;
		settle(6);
		chk_byte(pin_pullup_en[7:0], 8'hFF);
		ext_val <= 24'h000000;
		wait_sig(3);
		chk_bit(wake_pulse, 1'b1);
		chk_bit(stop_active, 1'b0);
		irq_ack1 <= 1'b1;
		tick();
		irq_ack1 <= 1'b0;
		wr(8'hC8, 8'h50);
		settle(3);
		chk_bit(irq_vec1, 1'b1);
		ext_en <= 24'h000100;
		settle(8);
		chk_bit(irq_vec1, 1'b0);
		wr(8'hCD, 8'h01);
		wr(8'hC8, 8'h30);
		settle(6);
		ext_val <= 24'h000100;
		wait_sig(2);
		chk_bit(irq_vec2, 1'b1);
		irq_ack2 <= 1'b1;
		tick();
		irq_ack2 <= 1'b0;
		ext_en <= 24'h000000;
		seed = lfsr(seed);
		r = seed[15:8];
		wr(8'hC5, 8'hFF);
		wr(8'hCD, 8'h0F);
		wr(8'hC1, r);
		settle(2);
		chk_bit(irq_vec2, 1'b0);
		chk_byte(pin_oe[15:8], {~r[7:4], 4'hF});
		chk_byte(pin_out[15:8], {4'h0, r[3:0]});
		rd(8'hC1, r);
		// Nothing pending: wait is entered, and NMI wakes while enabled
		wait_req <= 1'b1;
		tick();
		wait_req <= 1'b0;
		settle(0);
		chk_bit(wait_active, 1'b1);
		nmi_req <= 1'b1;
		wait_sig(3);
		nmi_req <= 1'b0;
		chk_bit(wake_pulse, 1'b1);
		chk_bit(wait_active, 1'b0);
		// One analog pin only, reached from plain input; port0 bit0 cannot be analog
		wr(8'hC2, 8'h01);
		wr(8'hCE, 8'hFF);
		wr(8'hC0, 8'h01);
		wr(8'hCC, 8'h11);
		settle(2);
		chk(pin_analog_en, 24'h010000);
		stop_test();
	end
endmodule : bidir_port_with_pin_interrupts_tb_top
